// ### rtl/tpt_timer.v
// triggered pulse timer: counter, compares, shadows, outputs, apb slave
//
// Our own choices: the APB interface to the registers and the address map.
`include "tpt_defs.vh"
module tpt_timer
#(
    parameter CNT_W = 16
)
(
    // clock, reset, enable
    input wire ref_clk_i,
    input wire reset_i,
    input wire clk_en_i,
    // count clock tick from the prescaler
    input wire count_tick_i,
    // external trigger pin
    input wire trig_pin_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // timer outputs and event pulses
    output reg timer_out_first_o,
    output reg timer_out_second_o,
    output reg cycle_match_irq_o,
    output reg duty_match_irq_o
);
    reg [7:0] timer_control_reg_a_reg;
    reg [2:0] timer_control_reg_b_reg;
    reg [1:0] edge_select_reg_reg;
    reg [CNT_W-1:0] cycle_compare_reg_reg;
    reg [CNT_W-1:0] duty_compare_reg_reg;
    reg [CNT_W-1:0] cycle_shadow_buffer_reg;
    reg [CNT_W-1:0] duty_shadow_buffer_reg;
    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] count_next;
    reg run_reg;
    reg run_next;
    reg duty_written_reg;
    reg soft_used_reg;
    reg cyc_hit_reg;
    reg first_next;
    reg second_next;
    reg cyc_irq_next;
    reg duty_irq_next;
    reg reload;
    reg [31:0] rd_data;
    reg rd_ok;
    wire pin_edge;
    wire wr_en;
    wire soft_trig;
    wire trigger;
    wire count_enable_bit;
    wire [2:0] mode_select_field;
    wire is_pulse;
    wire is_oneshot;
    wire step;
    wire duty_hit;
    wire [CNT_W-1:0] duty_upcoming;

    // one count step; the counter wraps at its width
    function [CNT_W-1:0] count_inc;
        input [CNT_W-1:0] value;
        begin
            count_inc = value + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // in pulse mode a zero duty keeps the second output low for the whole period
    function duty_is_zero;
        input [CNT_W-1:0] duty;
        begin
            duty_is_zero = (duty == {CNT_W{1'b0}});
        end
    endfunction

    // a write lands only at the access edge where pready is seen high,
    // so a slow master never writes twice
    assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
    assign count_enable_bit = timer_control_reg_a_reg[`TPT_CE_BIT];
    assign mode_select_field =
        timer_control_reg_b_reg[`TPT_MODE_LSB +: `TPT_MODE_W];
    assign is_pulse = (mode_select_field == `TPT_MODE_PULSE);
    assign is_oneshot = (mode_select_field == `TPT_MODE_ONESHOT);
    // the soft trigger bit is write-only, a pulse on write of 1
    assign soft_trig = wr_en & (paddr_i == `TPT_ADDR_CTRL_B) &
        pwdata_i[`TPT_SWTRIG_BIT];
    assign trigger = count_enable_bit & (pin_edge | soft_trig);
    assign step = count_tick_i & run_reg;
    assign duty_hit = (count_reg == duty_shadow_buffer_reg);
    // duty in force after the next cycle clear, pending write included
    assign duty_upcoming = duty_written_reg ? duty_compare_reg_reg :
        duty_shadow_buffer_reg;

    tpt_edge_detect u_edge
    (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .trig_pin_i(trig_pin_i),
        .rise_en_i(edge_select_reg_reg[`TPT_EDGE_RISE]),
        .fall_en_i(edge_select_reg_reg[`TPT_EDGE_FALL]),
        .edge_o(pin_edge)
    );

    // counter sequencing, output levels and event pulses
    always @*
    begin
        count_next = count_reg;
        run_next = run_reg;
        first_next = timer_out_first_o;
        second_next = timer_out_second_o;
        cyc_irq_next = 1'b0;
        duty_irq_next = 1'b0;
        reload = 1'b0;
        if (!count_enable_bit)
        begin
            // stopping parks the counter ready for the next start
            run_next = 1'b0;
            count_next = `TPT_CNT_IDLE;
            second_next = 1'b0;
            first_next = 1'b0;
        end
        else if (is_pulse || is_oneshot)
        begin
            if (trigger && !(is_oneshot && run_reg))
            begin
                // a trigger wins over a same-cycle match event
                count_next = `TPT_CNT_ZERO;
                run_next = 1'b1;
                if (is_pulse)
                begin
                    first_next = ~timer_out_first_o;
                    // zero duty: the start edge is cancelled at once
                    second_next =
                        !duty_is_zero(duty_shadow_buffer_reg);
                end
                else
                begin
                    // delay of duty counts: high only if duty is zero
                    second_next = (duty_shadow_buffer_reg ==
                        `TPT_CNT_ZERO);
                    first_next = soft_trig;
                end
            end
            else if (step)
            begin
                if (cyc_hit_reg)
                begin
                    cyc_irq_next = 1'b1;
                    reload = is_pulse;
                    if (is_oneshot)
                    begin
                        run_next = 1'b0;
                        count_next = `TPT_CNT_IDLE;
                        second_next = 1'b0;
                        first_next = 1'b0;
                    end
                    else
                    begin
                        count_next = `TPT_CNT_ZERO;
                        // 0% still gives a duty event at each clear
                        second_next = !duty_is_zero(duty_upcoming);
                        duty_irq_next = duty_is_zero(duty_upcoming);
                        if (soft_used_reg)
                            first_next = ~timer_out_first_o;
                    end
                end
                else
                    count_next = count_inc(count_reg);
            end
            // early duty event in trigger modes, aligned to output edge
            if (run_next && !trigger && step && !cyc_hit_reg &&
                count_inc(count_reg) == duty_shadow_buffer_reg)
            begin
                duty_irq_next = 1'b1;
                second_next = is_oneshot;
            end
        end
        else
        begin
            // free counting used by event mode: start from zero
            if (!run_reg)
            begin
                run_next = 1'b1;
                count_next = `TPT_CNT_ZERO;
            end
            else if (count_tick_i)
            begin
                if (cyc_hit_reg)
                begin
                    cyc_irq_next = 1'b1;
                    count_next = `TPT_CNT_ZERO;
                    reload = 1'b1;
                end
                else
                    count_next = count_inc(count_reg);
                // duty event one step after its match
                if (duty_hit && mode_select_field == `TPT_MODE_EVENT)
                    duty_irq_next = 1'b1;
            end
        end
    end

    // state and outputs
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            count_reg <= `TPT_CNT_IDLE;
            run_reg <= 1'b0;
            cyc_hit_reg <= 1'b0;
            soft_used_reg <= 1'b0;
            cycle_shadow_buffer_reg <= `TPT_CMP_RESET;
            duty_shadow_buffer_reg <= `TPT_CMP_RESET;
            timer_out_first_o <= 1'b0;
            timer_out_second_o <= 1'b0;
            cycle_match_irq_o <= 1'b0;
            duty_match_irq_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            count_reg <= count_next;
            run_reg <= run_next;
            // match registered so the clear lands on the next step
            cyc_hit_reg <= run_next &&
                (count_next == cycle_shadow_buffer_reg);
            if (trigger)
                soft_used_reg <= soft_trig;
            timer_out_first_o <= first_next;
            timer_out_second_o <= second_next;
            cycle_match_irq_o <= cyc_irq_next;
            duty_match_irq_o <= duty_irq_next;
            // shadows follow compares while idle, else on a cycle clear after a duty write
            if ((reload && duty_written_reg) || !run_reg)
            begin
                cycle_shadow_buffer_reg <= cycle_compare_reg_reg;
                duty_shadow_buffer_reg <= duty_compare_reg_reg;
            end
        end
    end

    // register writes; a duty write arms the next shadow load
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            timer_control_reg_a_reg <= 8'h00;
            timer_control_reg_b_reg <= 3'h0;
            edge_select_reg_reg <= 2'h0;
            cycle_compare_reg_reg <= `TPT_CMP_RESET;
            duty_compare_reg_reg <= `TPT_CMP_RESET;
            duty_written_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            // write of duty wins over the clear at the same cycle
            if (reload || !run_reg)
                duty_written_reg <= 1'b0;
            if (wr_en)
            begin
                case (paddr_i)
                    `TPT_ADDR_CTRL_A:
                        timer_control_reg_a_reg <= pwdata_i[7:0];
                    `TPT_ADDR_CTRL_B:
                        timer_control_reg_b_reg <= pwdata_i[2:0];
                    `TPT_ADDR_EDGE:
                        edge_select_reg_reg <= pwdata_i[1:0];
                    `TPT_ADDR_CYCLE:
                        cycle_compare_reg_reg <= pwdata_i[CNT_W-1:0];
                    `TPT_ADDR_DUTY:
                    begin
                        duty_compare_reg_reg <= pwdata_i[CNT_W-1:0];
                        duty_written_reg <= 1'b1;
                    end
                    default:
                    begin
                        // read-only and unmapped offsets ignore writes
                    end
                endcase
            end
        end
    end

    // read mux; unmapped addresses answer with an error
    always @*
    begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (paddr_i)
            `TPT_ADDR_CTRL_A: rd_data[7:0] = timer_control_reg_a_reg;
            `TPT_ADDR_CTRL_B: rd_data[2:0] = timer_control_reg_b_reg;
            `TPT_ADDR_EDGE: rd_data[1:0] = edge_select_reg_reg;
            `TPT_ADDR_CYCLE: rd_data[CNT_W-1:0] = cycle_compare_reg_reg;
            `TPT_ADDR_DUTY: rd_data[CNT_W-1:0] = duty_compare_reg_reg;
            `TPT_ADDR_COUNT: rd_data[CNT_W-1:0] = count_reg;
            `TPT_ADDR_STATUS: rd_data[1:0] = {duty_written_reg, run_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // apb answer: no wait state, pready pulses for one cycle
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else if (clk_en_i)
        begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~rd_ok;
            if (psel_i && !penable_i && !pwrite_i)
                prdata_o <= rd_data;
        end
    end
endmodule // tpt_timer

// ### rtl/tpt_defs.vh
// register map, field positions and reset values of the triggered pulse timer
`ifndef TPT_DEFS_VH
`define TPT_DEFS_VH
`define TPT_ADDR_CTRL_A 12'h000
`define TPT_ADDR_CTRL_B 12'h004
`define TPT_ADDR_EDGE 12'h008
`define TPT_ADDR_CYCLE 12'h00c
`define TPT_ADDR_DUTY 12'h010
`define TPT_ADDR_COUNT 12'h014
`define TPT_ADDR_STATUS 12'h018
`define TPT_CE_BIT 7
`define TPT_MODE_LSB 0
`define TPT_MODE_W 3
`define TPT_SWTRIG_BIT 6
`define TPT_MODE_EVENT 3'h1
`define TPT_MODE_PULSE 3'h2
`define TPT_MODE_ONESHOT 3'h3
`define TPT_EDGE_RISE 0
`define TPT_EDGE_FALL 1
`define TPT_CNT_IDLE 16'hffff
`define TPT_CNT_ZERO 16'h0000
`define TPT_CMP_RESET 16'h0000
`endif

// ### rtl/tpt_edge_detect.v
// synchroniser and edge detector for the external trigger input
module tpt_edge_detect
(
    // clock, reset, enable
    input wire ref_clk_i,
    input wire reset_i,
    input wire clk_en_i,
    // trigger pin and edge choice
    input wire trig_pin_i,
    input wire rise_en_i,
    input wire fall_en_i,
    // detected edge
    output wire edge_o
);
    reg sync1_reg;
    reg sync2_reg;
    reg last_reg;

    // two flops, then a history flop; sync2 and the history flop feed the compare
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sync1_reg <= trig_pin_i;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
        end
    end

    // edge is a one-cycle pulse
    assign edge_o = clk_en_i &
        ((rise_en_i & sync2_reg & ~last_reg) |
         (fall_en_i & ~sync2_reg & last_reg));
endmodule // tpt_edge_detect

// ### tb/tpt_timer_properties.sv
// port-level checker for the triggered pulse timer
`include "tpt_defs.vh"
module tpt_timer_properties
#(
    parameter CNT_W = 16
)
(
    // clock, reset, enables
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic count_tick_i,
    input wire logic trig_pin_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // timer outputs and event pulses
    input wire logic timer_out_first_o,
    input wire logic timer_out_second_o,
    input wire logic cycle_match_irq_o,
    input wire logic duty_match_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] mode_q;
    logic ce_q;
    logic [15:0] cyc_q, duty_q;
    logic wr_acc;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // software view of mode and compares, since the counter is hidden
    assign wr_acc = psel_i && penable_i && pwrite_i;
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mode_q <= 3'h0;
            ce_q <= 1'b0;
            cyc_q <= 16'h0000;
            duty_q <= 16'h0000;
        end
        else if (wr_acc)
        begin
            if (paddr_i == `TPT_ADDR_CTRL_A) ce_q <= pwdata_i[7];
            if (paddr_i == `TPT_ADDR_CTRL_B) mode_q <= pwdata_i[2:0];
            if (paddr_i == `TPT_ADDR_CYCLE) cyc_q <= pwdata_i[15:0];
            if (paddr_i == `TPT_ADDR_DUTY) duty_q <= pwdata_i[15:0];
        end
    end
    AST_SETUP_ANSWER: assert property (
        psel_i && !penable_i && clk_en_i |=> pready_o)
        else $error("no answer in the cycle after setup");
    AST_READY_ONE: assert property (
        pready_o && clk_en_i |=> !pready_o)
        else $error("ready held longer than one cycle");
    AST_STOPPED_QUIET: assert property (
        !ce_q && !$past(ce_q) && !$past(ce_q, 2)
        |-> !cycle_match_irq_o && !duty_match_irq_o)
        else $error("event pulse while counting is disabled");
    AST_DUTY_FALL: assert property (
        mode_q == `TPT_MODE_PULSE && duty_match_irq_o && duty_q != 0
        |-> !timer_out_second_o && $past(timer_out_second_o))
        else $error("duty event not aligned with output fall");
    AST_ONESHOT_RISE: assert property (
        mode_q == `TPT_MODE_ONESHOT && duty_match_irq_o
        |-> timer_out_second_o && !$past(timer_out_second_o))
        else $error("duty event not aligned with pulse start");
    AST_PERIOD_START: assert property (
        mode_q == `TPT_MODE_PULSE && cycle_match_irq_o && duty_q != 0
        |-> timer_out_second_o)
        else $error("output low at period start");
    AST_CYCLE_PULSE: assert property (
        cycle_match_irq_o && cyc_q != 0 |=> !cycle_match_irq_o)
        else $error("cycle event longer than one cycle");
    AST_EVENT_NO_DUTY: assert property (
        mode_q == `TPT_MODE_EVENT && ce_q && duty_q > cyc_q
        |-> !duty_match_irq_o)
        else $error("duty event with duty above cycle");
    COV_PWM_CYCLE: cover property (
        mode_q == `TPT_MODE_PULSE && cycle_match_irq_o);
    COV_ONESHOT_DUTY: cover property (
        mode_q == `TPT_MODE_ONESHOT && duty_match_irq_o);
    COV_SLV_ERR: cover property (pslverr_o);
endmodule // tpt_timer_properties

bind tpt_timer tpt_timer_properties #(.CNT_W(CNT_W)) i_props (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .count_tick_i(count_tick_i), .trig_pin_i(trig_pin_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .timer_out_first_o(timer_out_first_o),
    .timer_out_second_o(timer_out_second_o),
    .cycle_match_irq_o(cycle_match_irq_o),
    .duty_match_irq_o(duty_match_irq_o));

// ### tb/tpt_trig_model.sv
// external trigger source driving the timer's trigger pin
module tpt_trig_model
#(
    parameter HOLD = 2
)
(
    // clock and request from the bench
    input wire logic ref_clk_i,
    input wire logic fire_i,
    // trigger pin toward the timer
    output logic trig_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    // pin rests low; held over two clocks so the synchroniser sees it
    always @(posedge ref_clk_i)
    begin
        if (fire_i && left == 0) left <= HOLD;
        else if (left > 0) left <= left - 1;
        trig_o <= (fire_i && left == 0) || left > 1;
    end
endmodule // tpt_trig_model

// ### tb/triggered_pulse_timer_tb.sv
// self-checking bench for the triggered pulse timer
`include "tpt_defs.vh"
module triggered_pulse_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, fire = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, first_o, second_o, cyc_irq, duty_irq;
    logic trig, err, f;
    int mismatches = 0, cmp_count = 0, cycles = 0, n, w, k;
    always #5 ref_clk_i = ~ref_clk_i;
    tpt_timer #(.CNT_W(16)) i_dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
        .count_tick_i(1'b1), .trig_pin_i(trig), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .timer_out_first_o(first_o),
        .timer_out_second_o(second_o), .cycle_match_irq_o(cyc_irq),
        .duty_match_irq_o(duty_irq));
    tpt_trig_model i_src (.ref_clk_i(ref_clk_i), .fire_i(fire),
        .trig_o(trig));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle cycle follows so strobes never re-toggle
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int t;
        t = 0;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do
            @(posedge ref_clk_i);
        while (pready_o !== 1'b1 && ++t < 20);
        chk(t < 20, 1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // stop, load compares, choose mode, then enable
    task automatic cfg(input logic [31:0] m, c, d);
        apb(1'b1, `TPT_ADDR_CTRL_A, 32'h0);
        apb(1'b1, `TPT_ADDR_CYCLE, c);
        apb(1'b1, `TPT_ADDR_DUTY, d);
        apb(1'b1, `TPT_ADDR_CTRL_B, m);
        apb(1'b1, `TPT_ADDR_CTRL_A, 32'h0000_0080);
    endtask
    // wait a cycle event, then measure the next period and high time
    task automatic period(input int exp_n, input int exp_hi);
        int p, hi;
        p = 0;
        do
            @(posedge ref_clk_i);
        while (cyc_irq !== 1'b1 && ++p < 300);
        p = 0;
        hi = 0;
        do
        begin
            @(posedge ref_clk_i);
            p++;
            hi += (second_o === 1'b1);
        end
        while (cyc_irq !== 1'b1 && p < 300);
        chk(p, exp_n);
        chk(hi, exp_hi);
    endtask
    task automatic duty_hits(output int cnt);
        cnt = 0;
        repeat (30)
        begin
            @(posedge ref_clk_i);
            cnt += (duty_irq === 1'b1);
        end
    endtask
    // hang guard well above the expected run length
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        chk(rd, 32'h0000_ffff);
        apb(1'b0, 12'h01c, 32'h0);
        chk(err, 1);
        chk(rd, 32'h0);
        apb(1'b1, `TPT_ADDR_EDGE, 32'h0000_0001);
        cfg(`TPT_MODE_PULSE, 32'h0000_0009, 32'h0000_0004);
        repeat (20) @(posedge ref_clk_i);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        chk(rd, 32'h0000_ffff);
        fire <= 1'b1;
        @(posedge ref_clk_i);
        fire <= 1'b0;
        period(10, 4);
        period(10, 4);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        chk(rd <= 9, 1);
        period(10, 4);
        f = first_o;
        apb(1'b1, `TPT_ADDR_CTRL_B, 32'h0000_0042);
        chk(first_o, !f);
        chk(second_o, 1);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        chk(rd <= 3, 1);
        period(10, 4);
        period(10, 4);
        f = first_o;
        repeat (9) @(posedge ref_clk_i);
        chk(first_o, f);
        @(posedge ref_clk_i);
        chk(first_o, !f);
        apb(1'b1, `TPT_ADDR_CYCLE, 32'h0000_0007);
        apb(1'b1, `TPT_ADDR_DUTY, 32'h0000_0002);
        period(8, 2);
        apb(1'b1, `TPT_ADDR_CYCLE, 32'h0000_000f);
        period(8, 2);
        apb(1'b1, `TPT_ADDR_DUTY, 32'h0000_0002);
        period(16, 2);
        apb(1'b1, `TPT_ADDR_DUTY, 32'h0000_0000);
        period(16, 0);
        duty_hits(k);
        chk(k > 0, 1);
        apb(1'b1, `TPT_ADDR_DUTY, 32'h0000_0010);
        period(16, 16);
        apb(1'b1, `TPT_ADDR_CTRL_A, 32'h0);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        w = rd;
        repeat (5) @(posedge ref_clk_i);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        chk(rd, w);
        cfg(`TPT_MODE_EVENT, 32'h0000_0005, 32'h0000_0002);
        duty_hits(k);
        chk(k > 0, 1);
        cfg(`TPT_MODE_EVENT, 32'h0000_0005, 32'h0000_0009);
        duty_hits(k);
        chk(k, 0);
        cfg(`TPT_MODE_ONESHOT, 32'h0000_0009, 32'h0000_0003);
        apb(1'b1, `TPT_ADDR_CTRL_B, 32'h0000_0043);
        n = 0;
        while (second_o !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(n, 3);
        chk(first_o, 1);
        fire <= 1'b1;
        w = 0;
        while (second_o === 1'b1 && w < 50)
        begin
            @(posedge ref_clk_i);
            fire <= 1'b0;
            w++;
        end
        chk(w, 7);
        repeat (15) @(posedge ref_clk_i);
        chk(first_o, 0);
        apb(1'b0, `TPT_ADDR_COUNT, 32'h0);
        chk(rd, 32'h0000_ffff);
        conclude();
    end
endmodule // triggered_pulse_timer_tb
